//--- rtl/dac_loader_pkg.sv
`default_nettype none
package dac_loader_pkg;

	////////////////////////////////////////////////////////////////////
	// word layout on the serial link
	localparam int WORD_BITS    = 11;
	localparam int ADDR_BITS    = 3;
	localparam int CODE_BITS    = 8;
	localparam int NUM_CHANNELS = 8;

	// value loaded by reset and by the preset pin
	localparam logic [CODE_BITS-1:0] MIDSCALE = 8'h80;

	// channel latch index per address (address n feeds channel n+1)
	localparam logic [ADDR_BITS-1:0] CHANNEL_ONE_LEVEL   = 3'h0;
	localparam logic [ADDR_BITS-1:0] CHANNEL_TWO_LEVEL   = 3'h1;
	localparam logic [ADDR_BITS-1:0] CHANNEL_THREE_LEVEL = 3'h2;
	localparam logic [ADDR_BITS-1:0] CHANNEL_FOUR_LEVEL  = 3'h3;
	localparam logic [ADDR_BITS-1:0] CHANNEL_FIVE_LEVEL  = 3'h4;
	localparam logic [ADDR_BITS-1:0] CHANNEL_SIX_LEVEL   = 3'h5;
	localparam logic [ADDR_BITS-1:0] CHANNEL_SEVEN_LEVEL = 3'h6;
	localparam logic [ADDR_BITS-1:0] CHANNEL_EIGHT_LEVEL = 3'h7;

	// reset values of the synchronisers and switch controls
	localparam logic SELECT_IDLE_RST = 1'b1;
	localparam logic POWER_UP_RST    = 1'b0;
	localparam logic PRESET_REL_RST  = 1'b0;

	// cycles from a synchronised select rise to the latch write
	localparam int LOAD_LATENCY = 3;

	////////////////////////////////////////////////////////////////////
	// one update word, address in the upper bits, msb first on the wire
	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [CODE_BITS-1:0] code;
	} dac_word_t;

	// host-driven link pins, timed to the serial clock
	typedef struct packed {
		logic chip_select_n;
		logic serial_in;
	} link_in_t;

	// loader sequence on the system clock
	typedef enum logic [1:0] {
		LD_IDLE    = 2'b00,
		LD_CAPTURE = 2'b01,
		LD_WRITE   = 2'b10
	} load_state_t;

endpackage
`default_nettype wire

//--- rtl/serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module serial_shifter (
	// link clock and reset
	input  wire logic                       sclk,
	input  wire logic                       rst,
	// link pins
	input  wire dac_loader_pkg::link_in_t  link,
	// assembled word, stable while select is high
	output var  dac_loader_pkg::dac_word_t shift_ff
);
	import dac_loader_pkg::*;

	////////////////////////////////////////////////////////////////////
	// shift one bit per rising edge while selected, lsb end takes the pin
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			shift_ff <= '0;
		end else if (!link.chip_select_n) begin
			shift_ff <= dac_word_t'({shift_ff[WORD_BITS-2:0], link.serial_in});
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks on the link domain
	a_shift_in: assert property (@(posedge sclk) disable iff (rst)
		!link.chip_select_n |=>
		shift_ff == {$past(shift_ff[WORD_BITS-2:0]), $past(link.serial_in)})
		else $error("shift register did not take serial bit");

	a_shift_hold: assert property (@(posedge sclk) disable iff (rst)
		link.chip_select_n |=> $stable(shift_ff))
		else $error("shift register moved while deselected");

	a_word_len: assert property (@(posedge sclk) disable iff (rst)
		(!link.chip_select_n)[*8] ##1 (!link.chip_select_n)[*3] |=>
		shift_ff[WORD_BITS-1] == $past(link.serial_in, 11))
		else $error("word is not the last eleven bits");

endmodule
`default_nettype wire

//--- rtl/octal_dac_serial_loader.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - update word is exactly eleven bits
// - three address bits, then eight code bits
// - address n loads channel n plus one
// - select low active; rise decodes and loads
// - serial data sampled on rising clock only
// - preset low loads midscale into every latch
// - shutdown opens references and outputs, keeps latches
// - shutdown release drives held codes again
// - eight latches change on load or preset
// - address then code, both msb first
// - shift only while select low
// - extra bits: last eleven are used
module octal_dac_serial_loader #(
	parameter int NUM_CH = dac_loader_pkg::NUM_CHANNELS
) (
	// system clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rst,
	// serial link from the host
	input  wire logic                          sclk,
	input  wire dac_loader_pkg::link_in_t     link,
	// static control pins
	input  wire logic                          midscale_preset_n,
	input  wire logic                          power_down_n,
	// channel levels
	output logic [NUM_CH-1:0][dac_loader_pkg::CODE_BITS-1:0] chan_level_ff,
	// analog switch controls
	output logic [NUM_CH-1:0]                  out_drive_en_ff,
	output logic                               upper_reference_en_ff,
	output logic                               lower_reference_en_ff,
	// load reporting
	output logic                               update_strobe_ff,
	output logic [dac_loader_pkg::ADDR_BITS-1:0] last_addr_ff
);
	import dac_loader_pkg::*;

	////////////////////////////////////////////////////////////////////
	// elaboration checks

	// the address field cannot reach more than eight latches
	if (NUM_CH < 1 || NUM_CH > (1 << ADDR_BITS)) begin : g_bad_count
		$error("NUM_CH must lie between 1 and 8");
	end

	////////////////////////////////////////////////////////////////////
	// declarations

	// word held by the link-side shift register
	dac_word_t   link_word;

	// select crossing into the system domain
	logic        cs_meta_ff;
	logic        cs_sync_ff;
	logic        cs_prev_ff;
	logic        cs_rise;

	// shutdown and preset-release crossings
	logic        pd_meta_ff;
	logic        pd_sync_ff;
	logic        ps_meta_ff;
	logic        ps_sync_ff;

	// loader sequence
	load_state_t state_ff;
	load_state_t nxt_state;
	dac_word_t   cap_ff;
	logic        in_range;
	logic        write_go;
	logic [NUM_CH-1:0] sel;

	////////////////////////////////////////////////////////////////////
	// address decode, shared by the latch write and its check

	// one-hot latch select; out-of-range addresses select nothing
	function automatic logic [NUM_CH-1:0] ch_select(
		input logic [ADDR_BITS-1:0] a
	);
		logic [NUM_CH-1:0] hot;
		hot = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			hot[i] = (a == ADDR_BITS'(i));
		end
		return hot;
	endfunction

	////////////////////////////////////////////////////////////////////
	// link domain: serial-to-parallel shift register

	// runs on the host's clock only, which may stop between frames
	serial_shifter u_shifter (
		.sclk     (sclk),
		.rst      (rst),
		.link     (link),
		.shift_ff (link_word)
	);

	////////////////////////////////////////////////////////////////////
	// crossings into the system clock

	// select level, two flops; idle high so reset makes no load
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cs_meta_ff <= SELECT_IDLE_RST;
			cs_sync_ff <= SELECT_IDLE_RST;
			cs_prev_ff <= SELECT_IDLE_RST;
		end else begin
			cs_meta_ff <= link.chip_select_n;
			cs_sync_ff <= cs_meta_ff;
			cs_prev_ff <= cs_sync_ff;
		end
	end

	// shutdown level, two flops; outputs stay open until it is seen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pd_meta_ff <= POWER_UP_RST;
			pd_sync_ff <= POWER_UP_RST;
		end else begin
			pd_meta_ff <= power_down_n;
			pd_sync_ff <= pd_meta_ff;
		end
	end

	// preset release, two flops; guards writes near release
	always_ff @(posedge clk_sys or posedge rst or negedge midscale_preset_n) begin
		if (rst) begin
			ps_meta_ff <= PRESET_REL_RST;
			ps_sync_ff <= PRESET_REL_RST;
		end else if (!midscale_preset_n) begin
			ps_meta_ff <= PRESET_REL_RST;
			ps_sync_ff <= PRESET_REL_RST;
		end else begin
			ps_meta_ff <= 1'b1;
			ps_sync_ff <= ps_meta_ff;
		end
	end

	// rising select marks the end of a frame
	assign cs_rise = cs_sync_ff && !cs_prev_ff;

	////////////////////////////////////////////////////////////////////
	// loader sequence

	// next state: idle, capture the quiet word, write one latch
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			LD_IDLE: begin
				if (cs_rise) begin
					nxt_state = LD_CAPTURE;
				end
			end
			LD_CAPTURE: begin
				nxt_state = LD_WRITE;
			end
			LD_WRITE: begin
				nxt_state = LD_IDLE;
			end
			default: begin
				nxt_state = LD_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= LD_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// the shift register is frozen while select is high, so sampling
	// it two cycles after the synchronised rise is a safe crossing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cap_ff <= '0;
		end else if (state_ff == LD_CAPTURE) begin
			cap_ff <= link_word;
		end
	end

	// first three bits address, last eight bits are the code
	assign in_range = 32'(cap_ff.addr) < NUM_CH;
	assign write_go = (state_ff == LD_WRITE) && ps_sync_ff && in_range;
	assign sel      = ch_select(cap_ff.addr);

	////////////////////////////////////////////////////////////////////
	// channel latches

	// preset acts without the clock and wins over a pending write
	always_ff @(posedge clk_sys or posedge rst or negedge midscale_preset_n) begin
		if (rst) begin
			chan_level_ff <= {NUM_CH{MIDSCALE}};
		end else if (!midscale_preset_n) begin
			chan_level_ff <= {NUM_CH{MIDSCALE}};
		end else if (write_go) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (sel[i]) begin
					chan_level_ff[i] <= cap_ff.code;
				end
			end
		end
	end

	// report which latch took the last update
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			update_strobe_ff <= 1'b0;
			last_addr_ff     <= '0;
		end else begin
			update_strobe_ff <= write_go;
			if (write_go) begin
				last_addr_ff <= cap_ff.addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// shutdown switches

	// shutdown only opens switches; latches are left alone so that
	// release brings back the held codes with no reload
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_drive_en_ff       <= '0;
			upper_reference_en_ff <= 1'b0;
			lower_reference_en_ff <= 1'b0;
		end else begin
			out_drive_en_ff       <= {NUM_CH{pd_sync_ff}};
			upper_reference_en_ff <= pd_sync_ff;
			lower_reference_en_ff <= pd_sync_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks on the system domain

	a_cs_rise_load: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		(state_ff == LD_IDLE && cs_rise) |->
		##3 (update_strobe_ff == ($past(ps_sync_ff) && $past(in_range))))
		else $error("select rise did not load within three cycles");

	a_load_target: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		write_go |=>
		chan_level_ff[$past(cap_ff.addr)] == $past(cap_ff.code))
		else $error("addressed latch did not take the code");

	a_last_addr: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		update_strobe_ff |->
		(last_addr_ff == $past(cap_ff.addr)) &&
		(chan_level_ff[last_addr_ff] == $past(cap_ff.code)))
		else $error("reported address does not match the write");

	a_hold_idle: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		!write_go |=> $stable(chan_level_ff))
		else $error("latch changed without load or preset");

	a_preset_mid: assert property (
		@(posedge clk_sys) disable iff (rst)
		!midscale_preset_n |-> chan_level_ff == {NUM_CH{MIDSCALE}})
		else $error("preset did not force midscale");

	a_pd_open: assert property (
		@(posedge clk_sys) disable iff (rst)
		!pd_sync_ff |=> (out_drive_en_ff == '0) &&
		!upper_reference_en_ff && !lower_reference_en_ff)
		else $error("switches closed during shutdown");

	a_pd_resume: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		($rose(pd_sync_ff) && !write_go) |=>
		(&out_drive_en_ff) && upper_reference_en_ff && $stable(chan_level_ff))
		else $error("release did not drive the held codes");

	////////////////////////////////////////////////////////////////////
	// checks on the loader sequence and the switch pair

	// a write strobe never stretches into a second cycle
	a_strobe_pulse: assert property (
		@(posedge clk_sys) disable iff (rst)
		update_strobe_ff |=> !update_strobe_ff)
		else $error("update strobe wider than one cycle");

	// no strobe unless the cycle before it was a write cycle
	a_strobe_src: assert property (
		@(posedge clk_sys) disable iff (rst)
		update_strobe_ff |-> ($past(state_ff) == LD_WRITE))
		else $error("strobe seen without a write cycle");

	// capture is always followed by exactly one write cycle
	a_seq_capture: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state_ff == LD_CAPTURE) |=> (state_ff == LD_WRITE))
		else $error("capture was not followed by a write cycle");

	// the loader never stalls in the write cycle
	a_seq_return: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state_ff == LD_WRITE) |=> (state_ff == LD_IDLE))
		else $error("write cycle did not return to idle");

	// select must still be high while the frozen word is sampled
	a_cap_quiet: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state_ff == LD_CAPTURE) |-> cs_sync_ff)
		else $error("select fell again before the word was taken");

	// writes near a preset release are dropped, not deferred
	a_preset_drop: assert property (
		@(posedge clk_sys) disable iff (rst)
		(state_ff == LD_WRITE && !ps_sync_ff) |=> !update_strobe_ff)
		else $error("write went through while preset was active");

	// address zero must land in the first latch, not the second
	a_first_chan: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		(write_go && (cap_ff.addr == CHANNEL_ONE_LEVEL)) |=>
		(chan_level_ff[0] == $past(cap_ff.code)))
		else $error("address zero did not load the first latch");

	// a write selects exactly one latch
	a_one_latch: assert property (
		@(posedge clk_sys) disable iff (rst || !midscale_preset_n)
		write_go |-> $onehot(sel))
		else $error("write selected other than one latch");

	// both reference switches open and close together
	a_ref_pair: assert property (
		@(posedge clk_sys) disable iff (rst)
		upper_reference_en_ff == lower_reference_en_ff)
		else $error("reference switches disagree");

	// outputs close again once the release has been seen
	a_pd_close: assert property (
		@(posedge clk_sys) disable iff (rst)
		pd_sync_ff |=> (&out_drive_en_ff) && upper_reference_en_ff)
		else $error("switches stayed open after shutdown release");

endmodule
`default_nettype wire

//--- test/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
	// link pins toward the loader
	output var logic                     sclk,
	output var dac_loader_pkg::link_in_t link
);
	import dac_loader_pkg::*;

	////////////////////////////////////////////////////////////////////
	// quiet link: clock parked low, select idle
	initial begin
		sclk = 1'b0;
		link = '{chip_select_n: 1'b1, serial_in: 1'b0};
	end

	// one frame msb first, select kept off system edges; n above 11 overruns
	task automatic send(input logic [15:0] w, input int n);
		#0.5 link.chip_select_n = 1'b0;
		#15;
		for (int i = n - 1; i >= 0; i--) begin
			link.serial_in = w[i];
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
		#15 link.chip_select_n = 1'b1;
		// data released: flip it so a late sample shows up wrong
		link.serial_in = ~link.serial_in;
		#59.5;
	endtask

	// clock edges with select high and data toggling
	task automatic stray_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			link.serial_in = ~link.serial_in;
			#15 sclk = 1'b1;
			#15 sclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

//--- test/test_octal_dac_serial_loader.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_octal_dac_serial_loader;
	import dac_loader_pkg::*;
	logic            clk_sys, rst, sclk, midscale_preset_n, power_down_n;
	link_in_t        link;
	logic [7:0][7:0] lvl;
	logic [7:0]      drv_en;
	logic            ref_hi, ref_lo, strobe;
	logic [2:0]      last_addr;
	logic [7:0]      exp_lvl [8];
	int              failures, checks, strobes;

	////////////////////////////////////////////////////////////////////
	host_link_model host (.sclk(sclk), .link(link));

	octal_dac_serial_loader #(.NUM_CH(8)) DUT (
		.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .link(link),
		.midscale_preset_n(midscale_preset_n), .power_down_n(power_down_n),
		.chan_level_ff(lvl), .out_drive_en_ff(drv_en),
		.upper_reference_en_ff(ref_hi), .lower_reference_en_ff(ref_lo),
		.update_strobe_ff(strobe), .last_addr_ff(last_addr)
	);

	// system clock, 250 MHz
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// strobe is one cycle wide, so count it every edge
	always @(posedge clk_sys) begin
		if (strobe === 1'b1) strobes++;
	end

	////////////////////////////////////////////////////////////////////
	task report_and_stop;
		$display("failures=%0d checks=%0d", failures, checks);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task check_levels;
		for (int i = 0; i < 8; i++) `CMP(lvl[i], exp_lvl[i])
	endtask

	// send a frame; the low eleven bits of w are what should land
	task write_word(input logic [15:0] w, input int n, input logic take);
		int s;
		s = strobes;
		host.send(w, n);
		if (take) begin
			exp_lvl[w[10:8]] = w[7:0];
			`CMP(last_addr, w[10:8])
		end
		`CMP(strobes, s + int'(take))
		check_levels();
	endtask

	// bounded wait for the switch enables; exact figure is 3 edges
	task wait_en(input logic v);
		int i;
		for (i = 0; i < 8 && drv_en !== {8{v}}; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 8) begin
			failures++;
			report_and_stop();
		end
		`CMP(i, 3)
		`CMP({ref_hi, ref_lo}, {v, v})
	endtask

	////////////////////////////////////////////////////////////////////
	task sc_all_channels;
		for (int a = 0; a < 8; a++) write_word({5'h00, 3'(a), 8'(a * 37) ^ 8'h3c}, 11, 1'b1);
	endtask

	// extra lead bits must fall off the top
	task sc_overlong;
		write_word({3'b101, 3'h6, 8'h5a}, 14, 1'b1);
	endtask

	// stray edges with select high must not move the word
	task sc_stray_clocks;
		host.stray_clocks(5);
		write_word(16'h065a, 0, 1'b1);
	endtask

	task sc_preset;
		@(posedge clk_sys) midscale_preset_n <= 1'b0;
		#1;
		for (int i = 0; i < 8; i++) exp_lvl[i] = MIDSCALE;
		check_levels();
		write_word(16'h0123, 11, 1'b0);
		@(posedge clk_sys) midscale_preset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask

	// loads go on in shutdown and show once it ends
	task sc_shutdown;
		@(posedge clk_sys) power_down_n <= 1'b0;
		wait_en(1'b0);
		write_word(16'h05a5, 11, 1'b1);
		@(posedge clk_sys) power_down_n <= 1'b1;
		wait_en(1'b1);
		check_levels();
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		midscale_preset_n = 1'b1;
		power_down_n = 1'b1;
		failures = 0;
		checks = 0;
		strobes = 0;
		for (int i = 0; i < 8; i++) exp_lvl[i] = MIDSCALE;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		check_levels();
		wait_en(1'b1);
		sc_all_channels();
		sc_overlong();
		sc_stray_clocks();
		sc_preset();
		sc_shutdown();
		report_and_stop();
	end
endmodule
`default_nettype wire
